//--- rtl/bridge_ctrl_pkg.sv
package bridge_ctrl_pkg;

  // Configuration dword offsets, as byte addresses.
  localparam logic [7:0] OFS_BRIDGE_CONTROL = 8'h3C;
  localparam logic [7:0] OFS_SUBSYSTEM = 8'h40;

  // Bit positions inside the bridge control dword.
  localparam int BIT_PERR_RESP = 16;
  localparam int BIT_SERR_FWD = 17;
  localparam int BIT_ISA = 18;
  localparam int BIT_VGA = 19;
  localparam int BIT_MA_MODE = 21;
  localparam int BIT_SEC_RST = 22;
  localparam int BIT_FAST_B2B = 23;
  localparam int BIT_PTMO_SHORT = 24;
  localparam int BIT_STMO_SHORT = 25;
  localparam int BIT_TMO_STATUS = 26;
  localparam int BIT_TMO_SERR = 27;

  // Reset values of the writable fields.
  localparam logic [15:0] BCTL_RESET = 16'h0000;
  localparam logic [15:0] SSID_RESET = 16'h0000;

  // Discard timer limits in PCI clocks.
  localparam int TMO_LONG_CLKS = 32768;
  localparam logic [15:0] TMO_SHORT_CLKS = 16'h0400;

  // Legacy decode ranges.
  localparam logic [9:0] VGA_IO_A_LO = 10'h3B0;
  localparam logic [9:0] VGA_IO_A_HI = 10'h3BB;
  localparam logic [9:0] VGA_IO_B_LO = 10'h3C0;
  localparam logic [9:0] VGA_IO_B_HI = 10'h3DF;
  localparam logic [31:0] VGA_MEM_LO = 32'h000A0000;
  localparam logic [31:0] VGA_MEM_HI = 32'h000BFFFF;

  // One decoded bus request as seen on either side of the bridge.
  typedef struct packed {
    logic valid;
    logic is_io;
    logic is_mem;
    logic [31:0] addr;
  } xact_s;

  // Master abort report from either initiator interface.
  typedef struct packed {
    logic valid;
    logic delayed;
    logic read;
  } mabort_s;

endpackage : bridge_ctrl_pkg

//--- rtl/bridge_discard_timer.sv
`timescale 1ns/1ns
module bridge_discard_timer
  import bridge_ctrl_pkg::*;
#(
  parameter logic [15:0] LONG_LIMIT = 16'(TMO_LONG_CLKS)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic head,
  input wire logic retry,
  input wire logic short_sel,
  output logic discard
);

  // Counter and the discard pulse form the whole state.
  typedef struct packed {
    logic [15:0] cnt;
    logic discard;
  } tmr_s;

  tmr_s st_q, st_d;
  logic [15:0] limit;

  assign limit = short_sel ? TMO_SHORT_CLKS : LONG_LIMIT;
  assign discard = st_q.discard;

  // Count only while the completion waits at the head of the queue.
  always_comb begin
    st_d = st_q;
    st_d.discard = 1'b0;
    if (clr || retry || !head || st_q.discard) begin
      // A retry or a discard restarts the count for the next entry.
      st_d.cnt = 16'h0000;
    end else if (st_q.cnt == limit - 16'h0001) begin
      // The initiator never came back in time, so drop the entry.
      st_d.discard = 1'b1;
      st_d.cnt = 16'h0000;
    end else begin
      st_d.cnt = st_q.cnt + 16'h0001;
    end
  end

  // Registers.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : bridge_discard_timer

//--- rtl/bridge_decode.sv
`timescale 1ns/1ns
module bridge_decode
  import bridge_ctrl_pkg::*;
(
  input bridge_ctrl_pkg::xact_s pri,
  input bridge_ctrl_pkg::xact_s sec,
  input wire logic [31:0] io_base,
  input wire logic [31:0] io_limit,
  input wire logic isa_mode,
  input wire logic vga_mode,
  input wire logic io_en,
  input wire logic mem_en,
  output logic ds_fwd,
  output logic us_fwd
);

  // Classify one address against the windows and legacy ranges.
  function automatic logic [3:0] classify(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    logic in_win;
    logic isa_top;
    logic vga_io;
    logic vga_mem;
    in_win = (a >= lo) && (a <= hi);
    // Upper 768 bytes of a 1KB block inside the first 64KB.
    isa_top = (a[31:16] == 16'h0000) && (a[9:8] != 2'h0);
    // Bits 15:10 take no part in the legacy I/O match.
    vga_io = (a[31:16] == 16'h0000) && (((a[9:0] >= VGA_IO_A_LO) && (a[9:0] <= VGA_IO_A_HI)) ||
             ((a[9:0] >= VGA_IO_B_LO) && (a[9:0] <= VGA_IO_B_HI)));
    vga_mem = (a >= VGA_MEM_LO) && (a <= VGA_MEM_HI);
    return {in_win, isa_top, vga_io, vga_mem};
  endfunction : classify

  logic [3:0] pc;
  logic [3:0] sc;
  logic p_vga;
  logic s_vga;

  assign pc = classify(pri.addr, io_base, io_limit);
  assign sc = classify(sec.addr, io_base, io_limit);
  // Legacy video claims on the primary side only when both space enables are on; the secondary side ignores them.
  assign p_vga = vga_mode && io_en && mem_en && ((pri.is_io && pc[1]) || (pri.is_mem && pc[0]));
  assign s_vga = vga_mode && ((sec.is_io && sc[1]) || (sec.is_mem && sc[0]));

  // Downstream: legacy video first, then the I/O window with ISA holes.
  assign ds_fwd = pri.valid && (p_vga || (pri.is_io && pc[3] && !(isa_mode && pc[2])));
  // Upstream: outside the window, or an ISA alias, but never legacy video.
  assign us_fwd = sec.valid && sec.is_io && !s_vga && (!sc[3] || (isa_mode && sc[2]));

endmodule : bridge_decode

//--- rtl/bridge_control.sv
`timescale 1ns/1ns
// Behaviour
// - Parity response off silences secondary parity reporting.
// - Parity response on enables PERR and SERR.
// - Forward secondary SERR upstream when enabled.
// - ISA off forwards whole I/O window.
// - ISA on ignores upper 768 aliases downstream.
// - ISA on forwards upper 768 aliases upstream.
// - VGA on claims legacy video memory.
// - VGA on claims legacy video I/O.
// - VGA needs space enables; ignored on secondary.
// - VGA off only window decode applies.
// - Abort mode off completes with all ones.
// - Abort mode on gives target abort, SERR.
// - Bit 22 drives secondary reset directly.
// - No fast back-to-back; bit reads zero.
// - Primary discard timer, long or short limit.
// - Secondary discard timer, same selectable limits.
// - Discard sets status; write one clears.
// - Discard raises SERR when enabled.
// - Reserved bridge control bits read zero.
// - Writable subsystem vendor and subsystem identifiers.
// - Chip reset request sets secondary reset.
module bridge_control
  import bridge_ctrl_pkg::*;
#(
  parameter logic [15:0] TMO_LONG = 16'(TMO_LONG_CLKS)
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [3:0] CFG_BE,
  input wire logic [31:0] CFG_WDATA,
  output logic [31:0] CFG_RDATA,
  input wire logic CMD_SERR_EN,
  input wire logic CMD_IO_EN,
  input wire logic CMD_MEM_EN,
  input wire logic CHIP_RST_REQ,
  input wire logic SEC_DATA_PERR,
  input wire logic SEC_DATA_PERR_AS_MASTER,
  input wire logic SEC_ADDR_PERR,
  input wire logic SECONDARY_SYSTEM_ERROR_IN_N,
  input bridge_ctrl_pkg::mabort_s MABORT,
  input wire logic [1:0] HEAD_VALID,
  input wire logic [1:0] RETRY_SEEN,
  input bridge_ctrl_pkg::xact_s PRI_XACT,
  input bridge_ctrl_pkg::xact_s SEC_XACT,
  input wire logic [31:0] IO_BASE,
  input wire logic [31:0] IO_LIMIT,
  output logic SECONDARY_PARITY_ERROR_OUT_N,
  output logic SECONDARY_PARITY_ERROR_OUT_OE,
  output logic PRIMARY_SYSTEM_ERROR_OUT_N,
  output logic PRIMARY_SYSTEM_ERROR_OUT_OE,
  output logic DATA_PARITY_REPORTED,
  output logic SEC_RST_OUT_N,
  output logic SEC_IF_RESET,
  output logic FAST_B2B_GEN,
  output logic MA_COMPLETE_TRDY,
  output logic MA_ALL_ONES,
  output logic MA_TARGET_ABORT,
  output logic [1:0] DISCARD,
  output logic DS_FORWARD,
  output logic US_FORWARD
);

  import bridge_ctrl_pkg::*;

  // Whole register state of the block, filled by one process below.
  typedef struct packed {
    logic perr_resp;
    logic serr_fwd;
    logic isa_mode;
    logic vga_mode;
    logic ma_mode;
    logic sec_rst;
    logic ptmo_short;
    logic stmo_short;
    logic tmo_status;
    logic tmo_serr;
    logic [15:0] ssvid;
    logic [15:0] ssid;
    logic [31:0] rdata;
    logic [1:0] serr_sync;
    logic serr_prev;
    logic perr_drive;
    logic dpr;
    logic serr_drive;
    logic ma_trdy;
    logic ma_ones;
    logic ma_tabort;
    logic [1:0] discard;
    logic ds_fwd;
    logic us_fwd;
  } ctrl_s;

  ctrl_s st_q, st_d;
  logic [1:0] tmr_discard; // Discard pulses straight from the timers.
  logic ds_raw; // Combinational downstream claim.
  logic us_raw; // Combinational upstream claim.
  logic bctl_hit; // Access targets the bridge control dword.
  logic ssid_hit; // Access targets the subsystem identifier dword.
  logic sserr_edge; // New assertion seen on the secondary SERR input.
  logic [15:0] bctl_rd; // Bridge control field as software reads it.

  assign bctl_hit = (CFG_ADDR == OFS_BRIDGE_CONTROL);
  assign ssid_hit = (CFG_ADDR == OFS_SUBSYSTEM);
  // Only the second synchroniser stage and its delayed copy are used here.
  assign sserr_edge = !st_q.serr_sync[1] && st_q.serr_prev;

  // Reserved bits 20 and 31:28 and fast back-to-back bit 23 are tied low.
  assign bctl_rd = {4'h0, st_q.tmo_serr, st_q.tmo_status, st_q.stmo_short, st_q.ptmo_short, 1'b0,
                    st_q.sec_rst, st_q.ma_mode, 1'b0, st_q.vga_mode, st_q.isa_mode, st_q.serr_fwd,
                    st_q.perr_resp};

  // The two delayed-completion timers share one design.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_tmr
      bridge_discard_timer #(
        .LONG_LIMIT(TMO_LONG)
      ) u_tmr (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .clr(st_q.sec_rst),
        .head(HEAD_VALID[g]),
        .retry(RETRY_SEEN[g]),
        .short_sel((g == 0) ? st_q.ptmo_short : st_q.stmo_short),
        .discard(tmr_discard[g])
      );
    end
  endgenerate

  // Address decode for both buses.
  bridge_decode u_dec (
    .pri(PRI_XACT),
    .sec(SEC_XACT),
    .io_base(IO_BASE),
    .io_limit(IO_LIMIT),
    .isa_mode(st_q.isa_mode),
    .vga_mode(st_q.vga_mode),
    .io_en(CMD_IO_EN),
    .mem_en(CMD_MEM_EN),
    .ds_fwd(ds_raw),
    .us_fwd(us_raw)
  );

  // Next-state logic for registers, error reporting and abort handling.
  always_comb begin
    st_d = st_q;
    // Two-stage synchroniser for the asynchronous secondary SERR pin.
    st_d.serr_sync = {st_q.serr_sync[0], SECONDARY_SYSTEM_ERROR_IN_N};
    st_d.serr_prev = st_q.serr_sync[1];
    // Bridge control writes; each byte lane is honoured on its own.
    if (CFG_WR && bctl_hit) begin
      if (CFG_BE[2]) begin
        st_d.perr_resp = CFG_WDATA[BIT_PERR_RESP];
        st_d.serr_fwd = CFG_WDATA[BIT_SERR_FWD];
        st_d.isa_mode = CFG_WDATA[BIT_ISA];
        st_d.vga_mode = CFG_WDATA[BIT_VGA];
        st_d.ma_mode = CFG_WDATA[BIT_MA_MODE];
        st_d.sec_rst = CFG_WDATA[BIT_SEC_RST];
      end
      if (CFG_BE[3]) begin
        st_d.ptmo_short = CFG_WDATA[BIT_PTMO_SHORT];
        st_d.stmo_short = CFG_WDATA[BIT_STMO_SHORT];
        st_d.tmo_serr = CFG_WDATA[BIT_TMO_SERR];
        // Writing one clears the status; zero leaves it alone.
        if (CFG_WDATA[BIT_TMO_STATUS]) begin
          st_d.tmo_status = 1'b0;
        end
      end
    end
    // Subsystem identifiers, one byte lane at a time.
    if (CFG_WR && ssid_hit) begin
      if (CFG_BE[0]) begin
        st_d.ssvid[7:0] = CFG_WDATA[7:0];
      end
      if (CFG_BE[1]) begin
        st_d.ssvid[15:8] = CFG_WDATA[15:8];
      end
      if (CFG_BE[2]) begin
        st_d.ssid[7:0] = CFG_WDATA[23:16];
      end
      if (CFG_BE[3]) begin
        st_d.ssid[15:8] = CFG_WDATA[31:24];
      end
    end
    // A chip reset request forces secondary reset until software clears it.
    if (CHIP_RST_REQ) begin
      st_d.sec_rst = 1'b1;
    end
    // A discard in the same cycle as a clear still sets the status.
    if (tmr_discard != 2'b00) begin
      st_d.tmo_status = 1'b1;
    end
    // Read data is registered; unmapped offsets read as zero.
    if (CFG_RD && bctl_hit) begin
      st_d.rdata = {bctl_rd, 16'h0000};
    end else if (CFG_RD && ssid_hit) begin
      st_d.rdata = {st_q.ssid, st_q.ssvid};
    end else begin
      st_d.rdata = 32'h00000000;
    end
    // Secondary PERR is driven low for one clock per reported data error.
    st_d.perr_drive = SEC_DATA_PERR && st_q.perr_resp;
    st_d.dpr = SEC_DATA_PERR && SEC_DATA_PERR_AS_MASTER && st_q.perr_resp;
    // Primary SERR gathers every enabled system error source.
    st_d.serr_drive = CMD_SERR_EN && (
      (SEC_ADDR_PERR && st_q.perr_resp) ||
      (sserr_edge && st_q.serr_fwd) ||
      (MABORT.valid && !MABORT.delayed && st_q.ma_mode) ||
      ((tmr_discard != 2'b00) && st_q.tmo_serr));
    // Master abort outcome for delayed transactions.
    st_d.ma_trdy = MABORT.valid && MABORT.delayed && !st_q.ma_mode;
    st_d.ma_ones = MABORT.valid && MABORT.delayed && MABORT.read && !st_q.ma_mode;
    st_d.ma_tabort = MABORT.valid && MABORT.delayed && st_q.ma_mode;
    st_d.discard = tmr_discard;
    // Claims are cut off while the secondary side is held in reset.
    st_d.ds_fwd = ds_raw && !st_q.sec_rst;
    st_d.us_fwd = us_raw && !st_q.sec_rst;
  end

  // One register for the whole state; the synchroniser idles high.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      st_q <= '0;
      st_q.serr_sync <= 2'b11;
      st_q.serr_prev <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs all come from the state register, except FAST_B2B_GEN, which is tied low.
  assign CFG_RDATA = st_q.rdata;
  assign SECONDARY_PARITY_ERROR_OUT_N = !st_q.perr_drive;
  assign SECONDARY_PARITY_ERROR_OUT_OE = st_q.perr_drive;
  assign PRIMARY_SYSTEM_ERROR_OUT_N = !st_q.serr_drive;
  assign PRIMARY_SYSTEM_ERROR_OUT_OE = st_q.serr_drive;
  assign DATA_PARITY_REPORTED = st_q.dpr;
  assign SEC_RST_OUT_N = !st_q.sec_rst;
  assign SEC_IF_RESET = st_q.sec_rst;
  assign FAST_B2B_GEN = 1'b0;
  assign MA_COMPLETE_TRDY = st_q.ma_trdy;
  assign MA_ALL_ONES = st_q.ma_ones;
  assign MA_TARGET_ABORT = st_q.ma_tabort;
  assign DISCARD = st_q.discard;
  assign DS_FORWARD = st_q.ds_fwd;
  assign US_FORWARD = st_q.us_fwd;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  // A data parity error with response off never reaches the pin.
  perr_quiet_a: assert property (SEC_DATA_PERR && !st_q.perr_resp |=> !SECONDARY_PARITY_ERROR_OUT_OE)
    else $error("secondary PERR driven with parity response off");

  // With response on the pin follows the error one clock later.
  perr_drive_a: assert property (SEC_DATA_PERR && st_q.perr_resp |=> !SECONDARY_PARITY_ERROR_OUT_N)
    else $error("secondary PERR missing");

  // A new secondary SERR assertion is forwarded three clocks after the pin falls.
  sequence sserr_fall_s;
    SECONDARY_SYSTEM_ERROR_IN_N ##1 !SECONDARY_SYSTEM_ERROR_IN_N [*3];
  endsequence
  serr_fwd_a: assert property (sserr_fall_s ##0 (st_q.serr_fwd && CMD_SERR_EN) |=> !PRIMARY_SYSTEM_ERROR_OUT_N)
    else $error("secondary SERR not forwarded");

  // Abort mode off completes a delayed read with all ones and no target abort.
  ma_ones_a: assert property (MABORT.valid && MABORT.delayed && MABORT.read && !st_q.ma_mode
                              |=> MA_ALL_ONES && MA_COMPLETE_TRDY && !MA_TARGET_ABORT)
    else $error("master abort completion wrong");

  // Abort mode on signals target abort one clock later.
  ma_tabort_a: assert property (MABORT.valid && MABORT.delayed && st_q.ma_mode |=> MA_TARGET_ABORT && !MA_COMPLETE_TRDY)
    else $error("target abort missing");

  // A write of bit 22 reaches the reset pin on the next clock.
  sec_rst_a: assert property (CFG_WR && bctl_hit && CFG_BE[2] && !CHIP_RST_REQ
                              |=> SEC_RST_OUT_N == !$past(CFG_WDATA[BIT_SEC_RST]))
    else $error("secondary reset does not follow control");

  // A chip reset request asserts the secondary reset pin.
  chip_rst_a: assert property (CHIP_RST_REQ |=> !SEC_RST_OUT_N)
    else $error("chip reset did not assert secondary reset");

  // A discard always leaves the status set on the next clock.
  tmo_status_a: assert property ((tmr_discard != 2'b00) |=> st_q.tmo_status)
    else $error("timeout status not set");

  // A discard with both enables on pulses primary SERR.
  tmo_serr_a: assert property (DISCARD[0] && st_q.tmo_serr && CMD_SERR_EN |-> $past(PRIMARY_SYSTEM_ERROR_OUT_N) == 1'b1 ##0
                               !PRIMARY_SYSTEM_ERROR_OUT_N)
    else $error("timeout SERR missing");

  // Reserved and fast back-to-back bits never read as one.
  rsvd_zero_a: assert property ($past(CFG_RD && bctl_hit) |-> (CFG_RDATA[31:28] == 4'h0) && !CFG_RDATA[20] && !CFG_RDATA[23])
    else $error("reserved bridge control bit read as one");

  // A short-limit timer with an idle head discards after exactly 1024 clocks.
  tmr_short_a: assert property (st_q.ptmo_short && !st_q.sec_rst && HEAD_VALID[0] && !RETRY_SEEN[0] && g_tmr[0].u_tmr.st_q.cnt == 16'h03FF
                                |=> DISCARD[0] == 1'b0 ##0 tmr_discard[0])
    else $error("primary discard timer limit wrong");

  // Without the command enable the primary SERR driver stays off.
  serr_gate_a: assert property (!CMD_SERR_EN |=> !PRIMARY_SYSTEM_ERROR_OUT_OE)
    else $error("primary SERR driven while disabled");

  // Parity reported is flagged only when the bridge was master.
  dpr_master_a: assert property (SEC_DATA_PERR && !SEC_DATA_PERR_AS_MASTER |=> !DATA_PARITY_REPORTED)
    else $error("parity reported without master role");

  // A posted write abort in abort mode raises primary SERR.
  posted_serr_a: assert property (MABORT.valid && !MABORT.delayed && st_q.ma_mode && CMD_SERR_EN
                                  |=> !PRIMARY_SYSTEM_ERROR_OUT_N)
    else $error("posted abort did not raise SERR");

  // Legacy video memory on the primary bus is claimed when enabled.
  vga_mem_a: assert property (PRI_XACT.valid && PRI_XACT.is_mem && st_q.vga_mode && CMD_IO_EN && CMD_MEM_EN &&
                              !st_q.sec_rst && (PRI_XACT.addr >= VGA_MEM_LO) && (PRI_XACT.addr <= VGA_MEM_HI)
                              |=> DS_FORWARD)
    else $error("legacy video memory not claimed");

  // Legacy video I/O seen on the secondary bus never goes upstream.
  sec_vga_a: assert property (SEC_XACT.valid && SEC_XACT.is_io && st_q.vga_mode &&
                              (SEC_XACT.addr[31:16] == 16'h0000) && (SEC_XACT.addr[9:0] >= VGA_IO_B_LO) &&
                              (SEC_XACT.addr[9:0] <= VGA_IO_B_HI) |=> !US_FORWARD)
    else $error("legacy video I/O sent upstream");

  // Claims stay off while the secondary side is held in reset.
  rst_claim_a: assert property (st_q.sec_rst |=> !DS_FORWARD && !US_FORWARD)
    else $error("claim made during secondary reset");

  // Writing one clears the status unless a discard lands with it.
  status_clr_a: assert property (CFG_WR && bctl_hit && CFG_BE[3] && CFG_WDATA[BIT_TMO_STATUS] &&
                                 (tmr_discard == 2'b00) |=> !st_q.tmo_status)
    else $error("timeout status not cleared");

endmodule : bridge_control

//--- test/sec_bus_peer.sv
`timescale 1ns/1ns
// Far-side agents: a secondary device that raises system error, and initiators that repeat requests.
module sec_bus_peer (
  input wire logic clk,
  output logic serr_n,
  output logic [1:0] retry
);
  // The error line has a pull-up, so it idles high whenever no agent pulls it.
  initial begin
    serr_n = 1'b1;
    retry = 2'b00;
  end

  // Pull the error line low for n cycles, then let the pull-up restore it.
  task automatic pulse_serr(input int n);
    serr_n = 1'b0;
    repeat (n) @(posedge clk);
    #1 serr_n = 1'b1;
  endtask : pulse_serr

  // An initiator repeats its delayed request for one cycle on side i.
  task automatic rep(input int i);
    retry[i] = 1'b1;
    @(posedge clk);
    #1 retry[i] = 1'b0;
  endtask : rep
endmodule : sec_bus_peer

//--- test/tb_top.sv
`timescale 1ns/1ns
// Self-checking bench for the bridge control block.
module tb_top;
  import bridge_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic [31:0] cfg_rdata;
  logic serr_en = 1'b1;
  logic io_en = 1'b1;
  logic mem_en = 1'b1;
  logic dpm = 1'b1;
  logic [31:0] io_lim = 32'h0000_1FFF;
  logic chip_req = 1'b0;
  logic dperr = 1'b0;
  logic aperr = 1'b0;
  logic sec_serr_n;
  logic [1:0] retry;
  mabort_s ma = '0;
  logic [1:0] head = 2'b00;
  xact_s px = '0;
  xact_s sx = '0;
  logic perr_n, perr_oe, serr_n, serr_oe, dpr, srst_n, sif_rst, fb2b, trdy, ones, tabt, dsf, usf;
  logic [1:0] disc;
  int err_count = 0;
  int n_compared = 0;
  // Pulse counters: serr, perr, parity reported, trdy, all ones, target abort, discard 0, discard 1.
  int ev[8] = '{default: 0};

  // Clock of 10 ns period.
  always #5 clk = ~clk;

  sec_bus_peer peer (.clk(clk), .serr_n(sec_serr_n), .retry(retry));

  // Short discard limit keeps the long-timer scenarios brief.
  bridge_control #(.TMO_LONG(16'h0040)) DUT (
    .CLK_SYS(clk), .RST_N(rst_n), .CFG_WR(cfg_wr), .CFG_RD(cfg_rd), .CFG_ADDR(cfg_addr),
    .CFG_BE(cfg_be), .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata), .CMD_SERR_EN(serr_en),
    .CMD_IO_EN(io_en), .CMD_MEM_EN(mem_en), .CHIP_RST_REQ(chip_req), .SEC_DATA_PERR(dperr),
    .SEC_DATA_PERR_AS_MASTER(dpm), .SEC_ADDR_PERR(aperr), .SECONDARY_SYSTEM_ERROR_IN_N(sec_serr_n),
    .MABORT(ma), .HEAD_VALID(head), .RETRY_SEEN(retry), .PRI_XACT(px), .SEC_XACT(sx),
    .IO_BASE(32'h0000_1000), .IO_LIMIT(io_lim), .SECONDARY_PARITY_ERROR_OUT_N(perr_n),
    .SECONDARY_PARITY_ERROR_OUT_OE(perr_oe), .PRIMARY_SYSTEM_ERROR_OUT_N(serr_n),
    .PRIMARY_SYSTEM_ERROR_OUT_OE(serr_oe), .DATA_PARITY_REPORTED(dpr), .SEC_RST_OUT_N(srst_n),
    .SEC_IF_RESET(sif_rst), .FAST_B2B_GEN(fb2b), .MA_COMPLETE_TRDY(trdy), .MA_ALL_ONES(ones),
    .MA_TARGET_ABORT(tabt), .DISCARD(disc), .DS_FORWARD(dsf), .US_FORWARD(usf)
  );

  // Pulses are counted on the falling edge, well clear of the rising-edge updates.
  always @(negedge clk) begin
    ev[0] += int'(serr_oe === 1'b1 && serr_n === 1'b0);
    ev[1] += int'(perr_oe === 1'b1 && perr_n === 1'b0);
    ev[2] += int'(dpr === 1'b1);
    ev[3] += int'(trdy === 1'b1);
    ev[4] += int'(ones === 1'b1);
    ev[5] += int'(tabt === 1'b1);
    ev[6] += int'(disc[0] === 1'b1);
    ev[7] += int'(disc[1] === 1'b1);
  end

  // One comparison; four-state inequality so an unknown never passes.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Each counter must hold exactly one pulse where the mask bit is set, none elsewhere.
  task automatic pulses(input logic [7:0] exp, input string m);
    for (int i = 0; i < 8; i++) begin
      chk(32'(ev[i]), {31'h0, exp[i]}, m);
    end
    ev = '{default: 0};
  endtask : pulses

  // Wait n rising edges and land just after the last one.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // Config write; a spare cycle keeps the strobe from being re-raised in the same step.
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    cyc(1);
    cfg_wr = 1'b0;
    cyc(1);
  endtask : wr

  // Config read; data is registered and stands only in the cycle after the strobe.
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
    cfg_rd = 1'b1;
    cfg_addr = a;
    cyc(1);
    cfg_rd = 1'b0;
    chk(cfg_rdata, exp, m);
    cyc(1);
  endtask : rdc

  // Pulse {data perr, addr perr, abort valid, delayed, read} for one cycle, then let outputs settle.
  task automatic hit(input logic [4:0] v);
    {dperr, aperr, ma.valid, ma.delayed, ma.read} = v;
    cyc(1);
    {dperr, aperr, ma.valid, ma.delayed, ma.read} = 5'h00;
    cyc(3);
  endtask : hit

  // Present one request on a side and compare the claim one cycle later.
  task automatic dec(input logic [31:0] c, input logic p, input logic io, input logic [31:0] a,
                     input logic e);
    wr(8'h3C, 4'hF, c);
    if (p) begin
      px = '{valid: 1'b1, is_io: io, is_mem: !io, addr: a};
    end else begin
      sx = '{valid: 1'b1, is_io: io, is_mem: !io, addr: a};
    end
    cyc(1);
    chk({31'h0, p ? dsf : usf}, {31'h0, e}, "decode claim");
    px = '0;
    sx = '0;
  endtask : dec

  // Print the verdict and stop; both the sequence and the watchdog end here.
  task automatic end_sim;
    if (err_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // Watchdog sized well above the roughly 1330 cycles the sequence needs.
  initial begin
    #200000;
    err_count++;
    $display("FAIL %0t watchdog expired", $time);
    end_sim();
  end

  // Main sequence.
  initial begin
    cyc(2);
    rst_n = 1'b1;
    rdc(8'h3C, 32'h0, "ctl reset");
    rdc(8'h40, 32'h0, "ids reset");
    wr(8'h40, 4'h5, 32'hA5C3_5A3C);
    rdc(8'h40, 32'h00C3_003C, "ids lanes");
    wr(8'h40, 4'hF, 32'hA5C3_5A3C);
    rdc(8'h40, 32'hA5C3_5A3C, "ids full");
    rdc(8'h44, 32'h0, "unmapped");
    // Only lane 2 reaches the control bits this time.
    wr(8'h3C, 4'h4, 32'hFFFF_FFFF);
    rdc(8'h3C, 32'h006F_0000, "ctl lane");
    wr(8'h3C, 4'hF, 32'hFFFF_FFFF);
    rdc(8'h3C, 32'h0B6F_0000, "ctl ones");
    chk({30'h0, srst_n, sif_rst}, 32'h1, "sec reset on");
    chk({31'h0, fb2b}, 32'h0, "no fast b2b");
    rdc(8'h40, 32'hA5C3_5A3C, "ids kept");
    dec(32'h0040_0000, 1'b1, 1'b1, 32'h1100, 1'b0);
    wr(8'h3C, 4'hF, 32'h0);
    chk({30'h0, srst_n, sif_rst}, 32'h2, "sec reset off");
    chip_req = 1'b1;
    cyc(1);
    chip_req = 1'b0;
    cyc(1);
    rdc(8'h3C, 32'h0040_0000, "chip reset");
    chk({31'h0, srst_n}, 32'h0, "chip reset pin");
    // Parity reporting silenced, then enabled.
    wr(8'h3C, 4'hF, 32'h0);
    hit(5'h18);
    pulses(8'h00, "parity off");
    wr(8'h3C, 4'hF, 32'h0001_0000);
    hit(5'h18);
    pulses(8'h07, "parity on");
    // Not master and no command enable: only the PERR pin fires.
    dpm = 1'b0;
    serr_en = 1'b0;
    hit(5'h18);
    pulses(8'h02, "parity gated");
    dpm = 1'b1;
    serr_en = 1'b1;
    // Master abort in both modes, delayed read and posted write.
    wr(8'h3C, 4'hF, 32'h0);
    hit(5'h07);
    pulses(8'h18, "abort delayed");
    hit(5'h04);
    pulses(8'h00, "abort posted");
    wr(8'h3C, 4'hF, 32'h0020_0000);
    hit(5'h07);
    pulses(8'h20, "target abort");
    hit(5'h04);
    pulses(8'h01, "posted serr");
    // Secondary system error forwarding, enabled then disabled.
    wr(8'h3C, 4'hF, 32'h0002_0000);
    peer.pulse_serr(3);
    cyc(6);
    pulses(8'h01, "forward on");
    wr(8'h3C, 4'hF, 32'h0);
    peer.pulse_serr(3);
    cyc(6);
    pulses(8'h00, "forward off");
    // Long primary limit with error signalling on.
    wr(8'h3C, 4'hF, 32'h0800_0000);
    head[0] = 1'b1;
    cyc(60);
    pulses(8'h00, "early");
    cyc(8);
    head[0] = 1'b0;
    pulses(8'h41, "discard");
    rdc(8'h3C, 32'h0C00_0000, "status set");
    wr(8'h3C, 4'hF, 32'h0800_0000);
    rdc(8'h3C, 32'h0C00_0000, "write zero");
    wr(8'h3C, 4'hF, 32'h0C00_0000);
    rdc(8'h3C, 32'h0800_0000, "write one");
    // A repeat before expiry restarts the count.
    head[0] = 1'b1;
    cyc(40);
    peer.rep(0);
    cyc(40);
    head[0] = 1'b0;
    pulses(8'h00, "retried");
    // Short limits on both sides, error signalling off.
    wr(8'h3C, 4'hF, 32'h0300_0000);
    head = 2'b11;
    cyc(1018);
    pulses(8'h00, "short early");
    cyc(10);
    head = 2'b00;
    pulses(8'hC0, "short discard");
    // Address decode in each mode.
    dec(32'h0, 1'b1, 1'b1, 32'h1100, 1'b1);
    dec(32'h0004_0000, 1'b1, 1'b1, 32'h1100, 1'b0);
    dec(32'h0004_0000, 1'b1, 1'b1, 32'h1000, 1'b1);
    dec(32'h0004_0000, 1'b0, 1'b1, 32'h1100, 1'b1);
    dec(32'h0, 1'b0, 1'b1, 32'h1100, 1'b0);
    dec(32'h0008_0000, 1'b1, 1'b0, 32'h000A_0000, 1'b1);
    dec(32'h0008_0000, 1'b1, 1'b0, 32'h000C_0000, 1'b0);
    dec(32'h0008_0000, 1'b1, 1'b1, 32'h0000_F3C0, 1'b1);
    dec(32'h0008_0000, 1'b1, 1'b1, 32'h0000_F3BC, 1'b0);
    dec(32'h0008_0000, 1'b1, 1'b1, 32'h0001_03C0, 1'b0);
    dec(32'h0008_0000, 1'b0, 1'b1, 32'h0000_03C0, 1'b0);
    dec(32'h0, 1'b1, 1'b0, 32'h000A_0000, 1'b0);
    io_en = 1'b0;
    dec(32'h0008_0000, 1'b1, 1'b1, 32'h0000_03C0, 1'b0);
    io_en = 1'b1;
    mem_en = 1'b0;
    dec(32'h0008_0000, 1'b1, 1'b0, 32'h000A_0000, 1'b0);
    mem_en = 1'b1;
    // A narrower window drops an address it used to cover.
    io_lim = 32'h0000_10FF;
    dec(32'h0, 1'b1, 1'b1, 32'h1100, 1'b0);
    end_sim();
  end
endmodule : tb_top
